/* sec_engine.sv */
// serial eeprom command engine: frame decoder, read shifter, write latch, program timer
// assumes all pins arrive asynchronous to clk_sys; the host serial clock is sampled, not used as clock
`timescale 1ns/1ps
`default_nettype none
`include "sec_defines.svh"

module sec_engine #(
	parameter int unsigned PROG_CYCLES = `SEC_PROG_CYCLES  // self-timed cycle length in clk_sys cycles
) (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic chipSelect,
	input  wire logic serial_clock_in,
	input  wire logic serial_data_in,
	input  wire logic word_organization_sel,
	output var  logic serialDataOut,
	output var  logic serialDataOutEn,
	output var  logic busy
);

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// word index of an address in either organization
	function automatic logic [7:0] secWordAddr(input logic [8:0] a, input logic x16);
		secWordAddr = x16 ? a[7:0] : a[8:1];
	endfunction : secWordAddr

	// special sub-command field of an address
	function automatic logic [1:0] secSubCmd(input logic [8:0] a, input logic x16);
		secSubCmd = x16 ? a[7:6] : a[8:7];
	endfunction : secSubCmd

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pinRaw;   // cs, clock, data, organization
	logic [3:0] syncA;    // first stage, read only by syncB
	logic [3:0] syncB;    // second stage, safe to use
	assign pinRaw = {chipSelect, serial_clock_in, serial_data_in, word_organization_sel};

	// two flops per pin; organization resets to x16, matching an open pin
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			syncA <= `SEC_SYNC_RESET;
			syncB <= `SEC_SYNC_RESET;
		end
		else if (clkEn)
		begin
			syncA <= pinRaw;
			syncB <= syncA;
		end
	end

	logic csIn;    // chip select, synchronised
	logic skIn;    // serial clock, synchronised
	logic dataIn;  // serial data, synchronised
	logic org16;   // high selects 16-bit words
	assign csIn   = syncB[3];
	assign skIn   = syncB[2];
	assign dataIn = syncB[1];
	assign org16  = syncB[0];

	// ----------------------------------------
	// frame decoder state
	// ----------------------------------------
	sec_pkg::sec_state_t state, next_state;        // decoder state
	sec_pkg::sec_prog_t  pending, next_pending;    // operation armed for deselect
	logic [4:0]  bitCnt, next_bitCnt;              // bit index inside a field
	logic [1:0]  opcode, next_opcode;              // received opcode
	logic [8:0]  addrReg, next_addrReg;            // received or running address
	logic [15:0] dataReg, next_dataReg;            // received write data
	logic        writeEn, next_writeEn;            // write protect latch, high permits
	logic        statusMode, next_statusMode;      // ready/busy reporting armed
	logic        doBit, next_doBit;                // serial output level
	logic        doEn, next_doEn;                  // serial output enable
	logic [3:0]  readIdx, next_readIdx;            // next bit of word to send
	logic        csPrev, skPrev;                   // edge detection history
	logic        progStart;                        // one-cycle start of a self-timed cycle
	logic        skRise;                           // serial clock rising edge seen
	logic [8:0]  shiftAddr;                        // address with current bit appended
	logic [8:0]  incAddr;                          // sequential read successor
	logic [4:0]  addrLast;                         // last address bit index
	logic [4:0]  dataLast;                         // last data bit index
	logic [3:0]  readMsb;                          // first bit of an outgoing word
	logic [15:0] memRdata;                         // array read data
	logic [15:0] readWord;                         // word as seen in current organization

	assign skRise    = skIn && !skPrev;
	assign shiftAddr = {addrReg[7:0], dataIn};
	assign addrLast  = org16 ? `SEC_ADDR16_LAST : `SEC_ADDR8_LAST;
	assign dataLast  = org16 ? `SEC_DATA16_LAST : `SEC_DATA8_LAST;
	assign readMsb   = org16 ? `SEC_MSB16 : `SEC_MSB8;
	// 8-bit width wraps the word address to zero after the last one
	assign incAddr   = org16 ? {1'b0, addrReg[7:0] + `SEC_WORD_STEP}
	                         : addrReg + {1'b0, `SEC_WORD_STEP};
	// odd byte address takes the upper lane
	assign readWord  = org16 ? memRdata
	                         : {`SEC_ZERO_BYTE, addrReg[0] ? memRdata[15:8] : memRdata[7:0]};

	// next values of the frame decoder
	always_comb
	begin
		next_state      = state;
		next_pending    = pending;
		next_bitCnt     = bitCnt;
		next_opcode     = opcode;
		next_addrReg    = addrReg;
		next_dataReg    = dataReg;
		next_writeEn    = writeEn;
		next_statusMode = statusMode;
		next_doBit      = doBit;
		next_doEn       = doEn;
		next_readIdx    = readIdx;
		progStart       = 1'b0;
		if (!csIn)
		begin
			// deselected: output floats, any read ends, frame restarts
			next_state   = sec_pkg::SEC_ST_START;
			next_bitCnt  = '0;
			next_doEn    = 1'b0;
			next_pending = sec_pkg::SEC_PROG_NONE;
			if (csPrev && state == sec_pkg::SEC_ST_DONE && pending != sec_pkg::SEC_PROG_NONE && !busy)
			begin
				progStart       = 1'b1;
				next_statusMode = 1'b1;
			end
		end
		else
		begin
			// selected after a program start: report ready/busy
			if (statusMode)
			begin
				next_doEn  = 1'b1;
				next_doBit = !busy;
			end
			if (skRise)
			begin
				unique case (state)
					sec_pkg::SEC_ST_START:
					begin
						// a one releases status output and, when not busy, is also the start bit
						if (dataIn)
						begin
							next_statusMode = 1'b0;
							next_doEn       = 1'b0;
							if (!busy)
							begin
								next_state   = sec_pkg::SEC_ST_OPCODE;
								next_addrReg = '0;
								next_bitCnt  = '0;
							end
						end
					end
					sec_pkg::SEC_ST_OPCODE:
					begin
						next_opcode = {opcode[0], dataIn};
						next_bitCnt = bitCnt + `SEC_BIT_STEP;
						if (bitCnt == `SEC_OPC_LAST)
						begin
							next_state  = sec_pkg::SEC_ST_ADDR;
							next_bitCnt = '0;
						end
					end
					sec_pkg::SEC_ST_ADDR:
					begin
						next_addrReg = shiftAddr;
						next_bitCnt  = bitCnt + `SEC_BIT_STEP;
						if (bitCnt == addrLast)
						begin
							next_bitCnt = '0;
							next_state  = sec_pkg::SEC_ST_DONE;
							unique case (opcode)
								`SEC_OPC_READ:
								begin
									// reads ignore the protect latch
									next_state   = sec_pkg::SEC_ST_READ;
									next_doEn    = 1'b1;
									next_doBit   = 1'b0;
									next_readIdx = readMsb;
								end
								`SEC_OPC_ERASE:
								begin
									if (writeEn)
										next_pending = sec_pkg::SEC_PROG_ERASE;
								end
								`SEC_OPC_WRITE:
								begin
									next_state = sec_pkg::SEC_ST_DATA;
								end
								`SEC_OPC_SPECIAL:
								begin
									// low address bits are don't-care
									unique case (secSubCmd(shiftAddr, org16))
										`SEC_SUB_WEN: next_writeEn = 1'b1;
										`SEC_SUB_WDS: next_writeEn = 1'b0;
										`SEC_SUB_ERASE_ALL_CMD:
										begin
											if (writeEn)
												next_pending = sec_pkg::SEC_PROG_ERASE_ALL_CMD;
										end
										`SEC_SUB_WRITE_ALL_CMD: next_state = sec_pkg::SEC_ST_DATA;
									endcase
								end
							endcase
						end
					end
					sec_pkg::SEC_ST_DATA:
					begin
						next_dataReg = {dataReg[14:0], dataIn};
						next_bitCnt  = bitCnt + `SEC_BIT_STEP;
						if (bitCnt == dataLast)
						begin
							next_bitCnt = '0;
							next_state  = sec_pkg::SEC_ST_DONE;
							if (writeEn)
								next_pending = (opcode == `SEC_OPC_WRITE) ? sec_pkg::SEC_PROG_WRITE
								                                          : sec_pkg::SEC_PROG_WRITE_ALL_CMD;
						end
					end
					sec_pkg::SEC_ST_DONE:
					begin
						// extra bits after a complete frame are ignored
						next_state = sec_pkg::SEC_ST_DONE;
					end
					sec_pkg::SEC_ST_READ:
					begin
						// words follow back to back, no separating zero
						next_doBit = readWord[readIdx];
						if (readIdx == '0)
						begin
							next_readIdx = readMsb;
							next_addrReg = incAddr;
						end
						else
							next_readIdx = readIdx - `SEC_IDX_STEP;
					end
				endcase
			end
		end
	end

	// registers of the frame decoder; protect latch clears at reset
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state      <= sec_pkg::SEC_ST_START;
			pending    <= sec_pkg::SEC_PROG_NONE;
			bitCnt     <= '0;
			opcode     <= '0;
			addrReg    <= '0;
			dataReg    <= '0;
			writeEn    <= 1'b0;
			statusMode <= 1'b0;
			doBit      <= 1'b0;
			doEn       <= 1'b0;
			readIdx    <= '0;
			csPrev     <= 1'b0;
			skPrev     <= 1'b0;
		end
		else if (clkEn)
		begin
			state      <= next_state;
			pending    <= next_pending;
			bitCnt     <= next_bitCnt;
			opcode     <= next_opcode;
			addrReg    <= next_addrReg;
			dataReg    <= next_dataReg;
			writeEn    <= next_writeEn;
			statusMode <= next_statusMode;
			doBit      <= next_doBit;
			doEn       <= next_doEn;
			readIdx    <= next_readIdx;
			csPrev     <= csIn;
			skPrev     <= skIn;
		end
	end

	assign serialDataOut   = doBit;
	assign serialDataOutEn = doEn;

	// ----------------------------------------
	// self-timed program cycle
	// ----------------------------------------
	logic [31:0] busyCnt, next_busyCnt;    // cycles left in the program cycle
	logic [7:0]  sweep, next_sweep;        // word being written
	logic        sweepOn, next_sweepOn;    // array writes still to do
	logic        progAll, next_progAll;    // all-location operation
	logic [1:0]  progBe, next_progBe;      // byte lanes written
	logic [15:0] progData, next_progData;  // value stored
	logic        next_busy;
	logic        memWe;                    // array write strobe
	logic        allKind;                  // pending op touches every word
	logic        eraseKind;                // pending op stores ones

	assign allKind   = pending == sec_pkg::SEC_PROG_ERASE_ALL_CMD || pending == sec_pkg::SEC_PROG_WRITE_ALL_CMD;
	assign eraseKind = pending == sec_pkg::SEC_PROG_ERASE || pending == sec_pkg::SEC_PROG_ERASE_ALL_CMD;

	// next values; the timer runs on clk_sys gated by clkEn, not on the host clock, so the host clock may stop
	always_comb
	begin
		next_busy     = busy;
		next_busyCnt  = busyCnt;
		next_sweep    = sweep;
		next_sweepOn  = sweepOn;
		next_progAll  = progAll;
		next_progBe   = progBe;
		next_progData = progData;
		memWe         = 1'b0;
		if (progStart)
		begin
			next_busy     = 1'b1;
			next_busyCnt  = PROG_CYCLES - `SEC_CNT_STEP;
			next_sweepOn  = 1'b1;
			next_progAll  = allKind;
			next_sweep    = allKind ? '0 : secWordAddr(addrReg, org16);
			next_progBe   = (allKind || org16) ? `SEC_BE_ALL : (addrReg[0] ? `SEC_BE_HI : `SEC_BE_LO);
			// a write overwrites the whole lane, which is the auto-clear
			next_progData = eraseKind ? `SEC_ERASED_WORD
			              : (org16 ? dataReg : {dataReg[7:0], dataReg[7:0]});
		end
		else if (busy)
		begin
			if (busyCnt == '0)
				next_busy = 1'b0;
			else
				next_busyCnt = busyCnt - `SEC_CNT_STEP;
			if (sweepOn)
			begin
				memWe = 1'b1;
				if (!progAll || sweep == `SEC_LAST_WORD)
					next_sweepOn = 1'b0;
				else
					next_sweep = sweep + `SEC_WORD_STEP;
			end
		end
	end

	// registers of the program timer
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			busy     <= 1'b0;
			busyCnt  <= '0;
			sweep    <= '0;
			sweepOn  <= 1'b0;
			progAll  <= 1'b0;
			progBe   <= '0;
			progData <= '0;
		end
		else if (clkEn)
		begin
			busy     <= next_busy;
			busyCnt  <= next_busyCnt;
			sweep    <= next_sweep;
			sweepOn  <= next_sweepOn;
			progAll  <= next_progAll;
			progBe   <= next_progBe;
			progData <= next_progData;
		end
	end

	// ----------------------------------------
	// storage array
	// ----------------------------------------
	sec_mem uMem (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.addr    (busy ? sweep : secWordAddr(addrReg, org16)),
		.we      (memWe),
		.be      (progBe),
		.wdata   (progData),
		.rdata   (memRdata)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cbSys @(posedge clk_sys); endclocking
	default disable iff (!resetn || !clkEn);

	sequence seqReadAddrDone;
		state == sec_pkg::SEC_ST_ADDR ##1 state == sec_pkg::SEC_ST_READ;
	endsequence

	AST_FRAME_LEN: assert property (state == sec_pkg::SEC_ST_ADDR && next_state == sec_pkg::SEC_ST_READ
		|-> bitCnt == addrLast) else $error("read frame ended at wrong bit count");
	AST_SAMPLE_EDGE: assert property ($changed(opcode) |-> $past(skRise && csIn))
		else $error("opcode bit taken without serial clock rise");
	AST_OE_SCOPE: assert property (doEn |-> (state == sec_pkg::SEC_ST_READ || statusMode))
		else $error("output enabled outside read or status");
	AST_STATUS_LEVEL: assert property (doEn && statusMode && $stable(busy) |-> doBit == !busy)
		else $error("status level does not match busy");
	AST_DUMMY_ONE: assert property (skRise && csIn && dataIn && statusMode |=> !doEn)
		else $error("status output not released by clocked one");
	AST_READ_ZERO: assert property (seqReadAddrDone |-> doEn && !doBit)
		else $error("read did not begin with a zero bit");
	AST_READ_EDGE: assert property ($past(state) == sec_pkg::SEC_ST_READ && state == sec_pkg::SEC_ST_READ
		&& $changed(doBit) |-> $past(skRise)) else $error("read bit changed without clock rise");
	AST_WRAP: assert property ($past(state) == sec_pkg::SEC_ST_READ && $changed(addrReg) && org16
		|-> addrReg[7:0] == $past(addrReg[7:0]) + `SEC_WORD_STEP) else $error("sequential address step wrong");
	AST_PROTECT: assert property (progStart |-> writeEn)
		else $error("program cycle started while writes disabled");
	AST_BUSY_HOLD: assert property ($rose(busy) |-> busy [*8])
		else $error("busy dropped early");
	AST_BUSY_END: assert property (busy && busyCnt == '0 && !progStart |=> !busy)
		else $error("busy did not end when timer expired");

endmodule : sec_engine
`default_nettype wire

/* sec_defines.svh */
// named constants of the serial eeprom command engine
// assumes inclusion by bare name from the engine and array design files
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

// ----------------------------------------
// frame field lengths, as last bit index
// ----------------------------------------
`define SEC_OPC_LAST      5'd1
`define SEC_ADDR16_LAST   5'd7
`define SEC_ADDR8_LAST    5'd8
`define SEC_DATA16_LAST   5'd15
`define SEC_DATA8_LAST    5'd7
`define SEC_BIT_STEP      5'd1
`define SEC_MSB16         4'hF
`define SEC_MSB8          4'h7
`define SEC_IDX_STEP      4'h1

// ----------------------------------------
// opcodes and special sub-commands
// ----------------------------------------
`define SEC_OPC_READ      2'b10
`define SEC_OPC_ERASE     2'b11
`define SEC_OPC_WRITE     2'b01
`define SEC_OPC_SPECIAL   2'b00
`define SEC_SUB_WEN       2'b11
`define SEC_SUB_WDS       2'b00
`define SEC_SUB_ERASE_ALL_CMD      2'b10
`define SEC_SUB_WRITE_ALL_CMD      2'b01

// ----------------------------------------
// array geometry and data values
// ----------------------------------------
`define SEC_WORDS         256
`define SEC_LAST_WORD     8'hFF
`define SEC_WORD_STEP     8'h01
`define SEC_ERASED_WORD   16'hFFFF
`define SEC_ZERO_BYTE     8'h00
`define SEC_BE_ALL        2'b11
`define SEC_BE_HI         2'b10
`define SEC_BE_LO         2'b01
`define SEC_SYNC_RESET    4'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define SEC_CLK_PERIOD_NS 5
`define SEC_PROG_TIME_NS  5000000
`define SEC_PROG_CYCLES   (`SEC_PROG_TIME_NS / `SEC_CLK_PERIOD_NS)
`define SEC_CNT_STEP      32'd1

`endif

/* sec_pkg.sv */
// types shared by the serial eeprom command engine files
// assumes sec_defines.svh is on the include path
`default_nettype none

package sec_pkg;

	// ----------------------------------------
	// frame decoder states
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEC_ST_START,   // waiting for start bit
		SEC_ST_OPCODE,  // collecting opcode
		SEC_ST_ADDR,    // collecting address
		SEC_ST_DATA,    // collecting write data
		SEC_ST_DONE,    // frame complete, waiting deselect
		SEC_ST_READ     // shifting read data out
	} sec_state_t;

	// ----------------------------------------
	// pending self-timed operation
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEC_PROG_NONE,
		SEC_PROG_WRITE,
		SEC_PROG_ERASE,
		SEC_PROG_ERASE_ALL_CMD,
		SEC_PROG_WRITE_ALL_CMD
	} sec_prog_t;

endpackage : sec_pkg

`default_nettype wire

/* sec_mem.sv */
// storage array: 256 words of 16 bits with byte lane enables
// assumes one access per cycle; read data registered one cycle after address
`timescale 1ns/1ps
`default_nettype none
`include "sec_defines.svh"

module sec_mem (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clkEn,
	input  wire logic [7:0]  addr,
	input  wire logic        we,
	input  wire logic [1:0]  be,
	input  wire logic [15:0] wdata,
	output var  logic [15:0] rdata
);

	// ----------------------------------------
	// array, one lane per byte
	// ----------------------------------------
	// a separate array per lane keeps each array to a single writing process
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane++)
		begin : gLane
			logic [7:0] cells [`SEC_WORDS];  // no reset: contents are nonvolatile

			// byte lane write, whole lane replaced so no prior clear is needed
			always_ff @(posedge clk_sys)
			begin
				if (clkEn && we && be[lane])
					cells[addr] <= wdata[lane*8 +: 8];
			end

			// registered read port of this lane
			always_ff @(posedge clk_sys or negedge resetn)
			begin
				if (!resetn)
					rdata[lane*8 +: 8] <= '0;
				else if (clkEn)
					rdata[lane*8 +: 8] <= cells[addr];
			end
		end
	endgenerate

endmodule : sec_mem
`default_nettype wire

/* sec_host_model.sv */
// host side of the serial link: frames, word reads, status polling
// assumes link pins are sampled by the engine; link clock 48 ns, held low outside frames
`timescale 1ns/1ps
`default_nettype none

module sec_host_model (
	input  wire logic        clk_sys,
	input  wire logic        dataOut,
	input  wire logic        dataOutEn,
	input  wire logic        busy,        // program timer level, reported with status
	output var  logic        chipSelect,
	output var  logic        serialClk,
	output var  logic        serialData,
	output var  logic        resValid,
	output var  logic [16:0] resWord
);
	// ----------------------------------------
	// line as seen by the host
	// ----------------------------------------
	logic lastOut = 1'b0;  // last driven level
	wire  logic seen;      // released line shows the inverse, never a stale level
	assign seen = dataOutEn ? dataOut : ~lastOut;

	// track driven level
	always @(posedge clk_sys)
	begin
		if (dataOutEn)
			lastOut <= dataOut;
	end

	initial
	begin
		chipSelect = 1'b0;
		serialClk  = 1'b0;
		serialData = 1'b0;
		resValid   = 1'b0;
		resWord    = 17'h00000;
	end

	// one link clock; line sampled just before the rise
	task automatic bitx(input logic b, output logic s);
		serialData = b;
		#24;
		s = seen;
		serialClk = 1'b1;
		#24;
		serialClk = 1'b0;
	endtask : bitx

	// start, opcode, address, data, msb first; stays selected
	task automatic send(input logic [31:0] bits, input int n);
		logic s;
		chipSelect = 1'b1;
		#50;
		for (int i = n - 1; i >= 0; i--)
			bitx(bits[i], s);
	endtask : send

	// deselect; long enough for the minimum deselect time
	task automatic desel();
		chipSelect = 1'b0;
		serialData = 1'b0;
		#300;
	endtask : desel

	// hand a result to the bench on clk_sys
	task automatic post(input logic [16:0] v);
		@(posedge clk_sys);
		resWord  <= v;
		resValid <= 1'b1;
		@(posedge clk_sys);
		resValid <= 1'b0;
	endtask : post

	// clock in zeros and collect n bits
	task automatic readw(input int n);
		logic [16:0] v;
		logic        s;
		v = 17'h00000;
		for (int i = 0; i < n; i++)
		begin
			bitx(1'b0, s);
			v = {v[15:0], s};
		end
		post(v);
	endtask : readw

	// select briefly and report the output enable
	task automatic probe();
		chipSelect = 1'b1;
		#60;
		post({16'h0000, dataOutEn});
		desel();
	endtask : probe

	// busy level, ready level, then release by a clocked one
	task automatic poll();
		logic s;
		chipSelect = 1'b1;
		#60;
		post({15'h0000, busy, seen});
		for (int i = 0; i < 1000 && seen !== 1'b1; i++)
			@(posedge clk_sys);
		post({15'h0000, busy, seen});
		bitx(1'b1, s);
		#30;
		post({16'h0000, dataOutEn});
		desel();
	endtask : poll
endmodule : sec_host_model

`default_nettype wire

/* tb.sv */
// self-checking bench of the serial eeprom command engine
// assumes sec_host_model drives the link; results compared in order of notes
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int PROG = 300;  // shortened program cycle
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        clkEn = 1'b1;
	logic        orgSel = 1'b1;    // 1 = 16-bit words
	wire  logic  cs, sclk, sdi, sdo, sdoEn, busy, resValid;
	wire  logic [16:0] resWord;
	logic [16:0] expq[$];          // expected results, oldest first
	logic [16:0] expNow;
	logic [31:0] rng = 32'd8049;
	logic [15:0] wa, x, y;
	logic [7:0]  b8;
	int          miscompares = 0;
	int          samples_checked = 0;

	always #2.5 clk_sys = ~clk_sys;

	sec_engine #(.PROG_CYCLES(PROG)) i_sec_engine (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
		.chipSelect(cs), .serial_clock_in(sclk), .serial_data_in(sdi), .word_organization_sel(orgSel),
		.serialDataOut(sdo), .serialDataOutEn(sdoEn), .busy(busy));
	sec_host_model i_sec_host_model (.clk_sys(clk_sys), .dataOut(sdo), .dataOutEn(sdoEn), .chipSelect(cs),
		.busy(busy), .serialClk(sclk), .serialData(sdi), .resValid(resValid), .resWord(resWord));

	// xorshift source
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd

	task automatic note(input logic [16:0] v);
		expq.push_back(v);
	endtask : note

	// whole frame then deselect
	task automatic cmd(input logic [31:0] bits, input int n);
		i_sec_host_model.send(bits, n);
		i_sec_host_model.desel();
	endtask : cmd

	// status sequence: busy, ready, released
	task automatic pollx();
		note(17'h2);
		note(17'h1);
		note(17'h0);
		i_sec_host_model.poll();
	endtask : pollx

	task automatic tally_and_finish();
		// notes never matched by a result add a single mismatch in total
		if (expq.size() != 0)
			miscompares++;
		$display("counts: %0d checked, %0d mismatches", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// monitor: oldest note against each result
	always @(posedge clk_sys)
	begin
		if (resValid === 1'b1)
		begin
			expNow = expq.pop_front();
			samples_checked++;
			if (resWord !== expNow)
			begin
				miscompares++;
				$display("MISMATCH resWord expected %h seen %h", expNow, resWord);
			end
		end
	end

	// watchdog well beyond the expected run
	initial
	begin
		#400000;
		miscompares++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		wa = 16'(rnd());
		x  = 16'(rnd());
		y  = 16'(rnd());
		b8 = 8'(rnd());
		cmd({3'b101, 8'h02, wa}, 27);
		note(17'h0);
		i_sec_host_model.probe();
		$display("test powerup_protect done");
		cmd({3'b100, 8'hC0}, 11);
		cmd({3'b100, 8'h40, wa}, 27);
		pollx();
		cmd({3'b101, 8'hFF, x}, 27);
		// a frozen clock enable must also freeze the program timer, so busy outlasts it
		@(posedge clk_sys);
		clkEn <= 1'b0;
		repeat (PROG + 50) @(posedge clk_sys);
		clkEn <= 1'b1;
		pollx();
		cmd({3'b101, 8'h00, y}, 27);
		pollx();
		cmd({3'b111, 8'h01}, 11);
		pollx();
		$display("test programming done");
		i_sec_host_model.send({3'b110, 8'hFF}, 11);
		note({1'b0, x});
		i_sec_host_model.readw(17);
		note({1'b0, y});
		i_sec_host_model.readw(16);
		note(17'h0FFFF);
		i_sec_host_model.readw(16);
		note({1'b0, wa});
		i_sec_host_model.readw(16);
		i_sec_host_model.desel();
		note(17'h0);
		i_sec_host_model.probe();
		$display("test sequential_read done");
		cmd({3'b100, 8'h00}, 11);
		cmd({3'b100, 8'h80}, 11);
		note(17'h0);
		i_sec_host_model.probe();
		i_sec_host_model.send({3'b110, 8'h02}, 11);
		note({1'b0, wa});
		i_sec_host_model.readw(17);
		i_sec_host_model.desel();
		cmd({3'b100, 8'hC0}, 11);
		cmd({3'b100, 8'h80}, 11);
		pollx();
		i_sec_host_model.send({3'b110, 8'h00}, 11);
		note(17'h0FFFF);
		i_sec_host_model.readw(17);
		i_sec_host_model.desel();
		$display("test protect_and_erase_all done");
		orgSel <= 1'b0;
		repeat (10) @(posedge clk_sys);
		cmd({3'b101, 9'h003, b8}, 20);
		pollx();
		i_sec_host_model.send({3'b110, 9'h003}, 12);
		note({9'h000, b8});
		i_sec_host_model.readw(9);
		i_sec_host_model.desel();
		i_sec_host_model.send({3'b110, 9'h002}, 12);
		note(17'h000FF);
		i_sec_host_model.readw(9);
		i_sec_host_model.desel();
		$display("test byte_mode done");
		repeat (5) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
